// ### rtl/fuse_config_pkg.sv
// constants, field positions and carrier types for the configuration latch
// assumes one 250 MHz system clock and synchronous active-high reset
package fuse_config_pkg;

    // =========================================================
    // reset values of the stored bytes (0 = programmed)
    localparam logic [7:0] EXT_DEFAULT = 8'hff;
    localparam logic [7:0] HIGH_DEFAULT = 8'hdf;
    localparam logic [7:0] LOW_DEFAULT = 8'h62;
    localparam logic [7:0] LOCK_DEFAULT = 8'hff;
    localparam logic [6:0] EXT_UNUSED_ONES = 7'h7f;
    localparam logic [5:0] LOCK_UNUSED_ONES = 6'h3f;

    // =========================================================
    // field positions
    localparam int EXT_SELF_WRITE_BIT = 0;
    localparam int HIGH_EXT_RESET_OFF_BIT = 7;
    localparam int HIGH_ONEWIRE_DEBUG_BIT = 6;
    localparam int HIGH_SERIAL_PERMIT_BIT = 5;
    localparam int HIGH_WATCHDOG_BIT = 4;
    localparam int HIGH_EEPROM_KEEP_BIT = 3;
    localparam int LOW_CLOCK_DIV_BIT = 7;
    localparam int LOW_CLOCK_OUT_BIT = 6;
    localparam int LOCK_ONE_BIT = 0;

    // =========================================================
    // store slot select
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_EXT = 2'h2;
    localparam logic [1:0] SEL_LOCK = 2'h3;

    // =========================================================
    // serial instruction bytes
    localparam logic [7:0] OP_WRITE = 8'hac;
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_WR_LOW = 8'ha0;
    localparam logic [7:0] SUB_WR_HIGH = 8'ha8;
    localparam logic [7:0] SUB_WR_EXT = 8'ha4;
    localparam logic [7:0] SUB_WR_LOCK = 8'he0;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_HIGH_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_LD_FLASH_LO = 8'h40;
    localparam logic [7:0] OP_LD_FLASH_HI = 8'h48;
    localparam logic [7:0] OP_LD_EEPROM = 8'hc1;
    localparam logic [7:0] SUB_ALT = 8'h08;

    // =========================================================
    // page geometry
    localparam int EEPROM_PAGE_BYTES = 4;
    localparam int FLASH_PAGE_WORDS_MAX = 32;
    localparam int FLASH_PAGES_MAX = 128;
    localparam int EEPROM_PAGES_MAX = 128;

    typedef struct packed {
        logic [7:0] lock;
        logic [7:0] ext;
        logic [7:0] high;
        logic [7:0] low;
    } config_image_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] sub;
        logic [7:0] arg;
    } instr_head_t;

    typedef enum logic [1:0] {
        LINK_OFF = 2'b00,
        LINK_SYNC = 2'b01,
        LINK_PROG = 2'b11
    } link_state_t;

endpackage : fuse_config_pkg

// ### rtl/cfg_pin_sync.sv
// two-flop synchroniser for pins arriving from outside the clock domain
// assumes i_rst is synchronous to i_clk_sys
`timescale 1ns/10ps
module cfg_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta_reg <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule : cfg_pin_sync

// ### rtl/nv_byte_store.sv
// stored configuration and lock bytes, image out of a register
// assumes writes are already screened by the programming engine
`timescale 1ns/10ps
module nv_byte_store
    import fuse_config_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_sel,
    input wire logic [7:0] i_wr_data,
    input wire logic i_erase_lock,
    output config_image_t o_image
);
    logic [7:0] mem_reg [4];

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mem_reg[SEL_LOW] <= LOW_DEFAULT;
            mem_reg[SEL_HIGH] <= HIGH_DEFAULT;
            mem_reg[SEL_EXT] <= EXT_DEFAULT;
            mem_reg[SEL_LOCK] <= LOCK_DEFAULT;
        end else if (i_erase_lock) begin
            mem_reg[SEL_LOCK] <= LOCK_DEFAULT;
        end else if (i_wr_en) begin
            mem_reg[i_wr_sel] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_image <= {LOCK_DEFAULT, EXT_DEFAULT, HIGH_DEFAULT, LOW_DEFAULT};
        end else begin
            o_image <= {mem_reg[SEL_LOCK], mem_reg[SEL_EXT], mem_reg[SEL_HIGH],
                mem_reg[SEL_LOW]};
        end
    end
endmodule : nv_byte_store

// ### rtl/fuse_config_latch.sv
// configuration byte latch with serial download engine
// assumes the reset pin, sck and mosi arrive asynchronously; store is local
`timescale 1ns/10ps

module fuse_config_latch
    import fuse_config_pkg::*;
#(
    parameter int FLASH_PAGE_WORDS = FLASH_PAGE_WORDS_MAX,
    parameter int FLASH_PAGES = FLASH_PAGES_MAX,
    parameter int EEPROM_PAGES = EEPROM_PAGES_MAX,
    parameter logic [7:0] CAL_BYTE = 8'h80,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // id value arbitrary
    parameter logic [7:0] SIG_BYTE1 = 8'h3c, // id value arbitrary
    parameter logic [7:0] SIG_BYTE2 = 8'h01, // id value arbitrary
    localparam int FWB = $clog2(FLASH_PAGE_WORDS),
    localparam int FPB = $clog2(FLASH_PAGES),
    localparam int EWB = $clog2(EEPROM_PAGE_BYTES),
    localparam int EPB = $clog2(EEPROM_PAGES)
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_prog_mode,
    output logic o_chip_erase,
    output logic o_eeprom_erase,
    output logic o_self_write_permit,
    output logic o_ext_reset_off,
    output logic o_onewire_debug_on,
    output logic o_serial_download_permit,
    output logic o_watchdog_forced_on,
    output logic o_eeprom_keep_on_erase,
    output logic [2:0] o_brownout_level,
    output logic o_clock_div_eight,
    output logic o_clock_pin_output,
    output logic [1:0] o_startup_time,
    output logic [3:0] o_clock_source_select,
    output logic [7:0] o_osc_trim_register,
    output logic [FWB-1:0] o_word_in_page_field,
    output logic [FPB-1:0] o_page_index_field,
    output logic [EWB-1:0] o_eeprom_byte_field,
    output logic [EPB-1:0] o_eeprom_page_field
);

    // =========================================================
    // helpers
    function automatic logic [15:0] low_part(input logic [15:0] a, input int bits);
        low_part = a & ((16'h0001 << bits) - 16'h0001);
    endfunction : low_part

    function automatic logic [15:0] high_part(input logic [15:0] a, input int bits);
        high_part = a >> bits;
    endfunction : high_part

    // =========================================================
    // pin synchronisers
    logic [2:0] pins_s;
    logic sck_s;
    logic mosi_s;
    logic rst_pin_n_s;

    cfg_pin_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async({i_reset_pin_n, i_sck, i_mosi}),
        .o_sync(pins_s)
    );
    assign rst_pin_n_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // =========================================================
    // declarations
    config_image_t image;
    config_image_t latched_reg;
    link_state_t state_reg;
    instr_head_t head_reg;
    logic sck_prev_reg;
    logic [4:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] tx_load_reg;
    logic tx_pend_reg;
    logic powerup_latch_reg;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [7:0] rx_next;
    logic link_hold;
    logic exec;
    logic enable_cmd;
    logic prog_active;
    logic fuses_locked;
    logic wr_en;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;
    logic erase;
    logic [7:0] reply;
    logic [15:0] load_addr;

    assign sck_rise = sck_s & ~sck_prev_reg;
    assign sck_fall = ~sck_s & sck_prev_reg;
    assign byte_done = sck_rise && (bit_cnt_reg[2:0] == 3'h7);
    assign rx_next = {rx_shift_reg[6:0], mosi_s};
    assign exec = byte_done && (bit_cnt_reg[4:3] == 2'h3);
    assign prog_active = (state_reg == LINK_PROG);
    assign fuses_locked = ~image.lock[LOCK_ONE_BIT];
    assign load_addr = {head_reg.sub, head_reg.arg};

    // serial download needs the pin low, pin acting as reset, permit programmed
    assign link_hold = ~rst_pin_n_s && latched_reg.high[HIGH_EXT_RESET_OFF_BIT]
        && ~latched_reg.high[HIGH_SERIAL_PERMIT_BIT];
    assign enable_cmd = (head_reg.op == OP_WRITE) && (head_reg.sub == SUB_ENABLE);

    // =========================================================
    // serial shifter
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !link_hold) begin
            bit_cnt_reg <= 5'h00;
            rx_shift_reg <= 8'h00;
            head_reg <= '0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            rx_shift_reg <= rx_next;
            if (byte_done) begin
                unique case (bit_cnt_reg[4:3])
                    2'h0: head_reg.op <= rx_next;
                    2'h1: head_reg.sub <= rx_next;
                    2'h2: head_reg.arg <= rx_next;
                    2'h3: head_reg <= head_reg;
                endcase
            end
        end
    end

    // =========================================================
    // read reply for the fourth byte
    always_comb begin
        reply = 8'h00;
        unique case (head_reg.op)
            OP_RD_FUSE: reply = (head_reg.sub == SUB_ALT) ? latched_reg.ext
                : latched_reg.low;
            OP_RD_HIGH_LOCK: reply = (head_reg.sub == SUB_ALT) ? latched_reg.high
                : image.lock;
            OP_RD_SIG: begin
                unique case (rx_next[1:0])
                    2'h0: reply = SIG_BYTE0;
                    2'h1: reply = SIG_BYTE1;
                    2'h2: reply = SIG_BYTE2;
                    2'h3: reply = 8'hff;
                endcase
            end
            OP_RD_CAL: reply = CAL_BYTE;
            default: reply = 8'h00;
        endcase
    end

    // output bits change on falling sck; the second byte is echoed in the third
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !link_hold) begin
            tx_shift_reg <= 8'h00;
            tx_load_reg <= 8'h00;
            tx_pend_reg <= 1'b0;
        end else begin
            if (byte_done) begin
                tx_pend_reg <= 1'b1;
                unique case (bit_cnt_reg[4:3])
                    2'h1: tx_load_reg <= rx_next;
                    2'h2: tx_load_reg <= reply;
                    default: tx_load_reg <= 8'h00;
                endcase
            end else if (sck_fall && tx_pend_reg) begin
                tx_pend_reg <= 1'b0;
                tx_shift_reg <= tx_load_reg;
            end else if (sck_fall) begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    assign o_miso = tx_shift_reg[7];
    assign o_miso_oe = link_hold;

    // =========================================================
    // link state
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= LINK_OFF;
        end else begin
            unique case (state_reg)
                LINK_OFF: if (link_hold) state_reg <= LINK_SYNC;
                LINK_SYNC: begin
                    if (!link_hold) begin
                        state_reg <= LINK_OFF;
                    end else if (exec && enable_cmd) begin
                        state_reg <= LINK_PROG;
                    end
                end
                LINK_PROG: if (!link_hold) state_reg <= LINK_OFF;
                default: state_reg <= LINK_OFF;
            endcase
        end
    end

    assign o_prog_mode = prog_active;

    // =========================================================
    // command execution, only after the enable instruction
    always_comb begin
        wr_en = 1'b0;
        wr_sel = SEL_LOW;
        wr_data = rx_next;
        erase = 1'b0;
        if (exec && prog_active && head_reg.op == OP_WRITE) begin
            unique case (head_reg.sub)
                SUB_ERASE: erase = 1'b1;
                SUB_WR_LOW: begin
                    wr_en = ~fuses_locked;
                    wr_sel = SEL_LOW;
                end
                SUB_WR_HIGH: begin
                    wr_en = ~fuses_locked;
                    wr_sel = SEL_HIGH;
                    wr_data[HIGH_SERIAL_PERMIT_BIT] =
                        image.high[HIGH_SERIAL_PERMIT_BIT];
                end
                SUB_WR_EXT: begin
                    wr_en = ~fuses_locked;
                    wr_sel = SEL_EXT;
                    wr_data = {EXT_UNUSED_ONES, rx_next[EXT_SELF_WRITE_BIT]};
                end
                SUB_WR_LOCK: begin
                    wr_en = 1'b1;
                    wr_sel = SEL_LOCK;
                    wr_data = image.lock & {LOCK_UNUSED_ONES, rx_next[1:0]};
                end
                default: wr_en = 1'b0;
            endcase
        end
    end

    nv_byte_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_wr_en(wr_en),
        .i_wr_sel(wr_sel),
        .i_wr_data(wr_data),
        .i_erase_lock(erase),
        .o_image(image)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_chip_erase <= 1'b0;
            o_eeprom_erase <= 1'b0;
        end else begin
            o_chip_erase <= erase;
            o_eeprom_erase <= erase && image.high[HIGH_EEPROM_KEEP_BIT];
        end
    end

    // =========================================================
    // working copy: power-up, programming entry and exit
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            powerup_latch_reg <= 1'b1;
            latched_reg <= {LOCK_DEFAULT, EXT_DEFAULT, HIGH_DEFAULT, LOW_DEFAULT};
        end else begin
            powerup_latch_reg <= 1'b0;
            if (powerup_latch_reg) begin
                latched_reg <= image;
            end else if (state_reg == LINK_SYNC && exec && enable_cmd) begin
                latched_reg <= image;
            end else if (prog_active && !link_hold) begin
                latched_reg <= image;
            end
        end
    end

    // downstream controls, single bits active high when programmed, multi-bit fields passed as stored
    always_comb begin
        o_self_write_permit = ~latched_reg.ext[EXT_SELF_WRITE_BIT];
        o_ext_reset_off = ~latched_reg.high[HIGH_EXT_RESET_OFF_BIT];
        o_onewire_debug_on = ~latched_reg.high[HIGH_ONEWIRE_DEBUG_BIT];
        o_serial_download_permit = ~latched_reg.high[HIGH_SERIAL_PERMIT_BIT];
        o_watchdog_forced_on = ~latched_reg.high[HIGH_WATCHDOG_BIT];
        o_brownout_level = latched_reg.high[2:0];
        o_clock_div_eight = ~latched_reg.low[LOW_CLOCK_DIV_BIT];
        o_clock_pin_output = ~latched_reg.low[LOW_CLOCK_OUT_BIT];
        o_startup_time = latched_reg.low[5:4];
        o_clock_source_select = latched_reg.low[3:0];
        o_eeprom_keep_on_erase = ~image.high[HIGH_EEPROM_KEEP_BIT];
    end

    // =========================================================
    // oscillator trim loaded while any reset is held
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_osc_trim_register <= CAL_BYTE;
        end else if (!rst_pin_n_s && latched_reg.high[HIGH_EXT_RESET_OFF_BIT]) begin
            o_osc_trim_register <= CAL_BYTE;
        end
    end

    // =========================================================
    // page address split of the load instructions
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_word_in_page_field <= '0;
            o_page_index_field <= '0;
            o_eeprom_byte_field <= '0;
            o_eeprom_page_field <= '0;
        end else if (byte_done && bit_cnt_reg[4:3] == 2'h2 && prog_active) begin
            if (head_reg.op == OP_LD_FLASH_LO || head_reg.op == OP_LD_FLASH_HI) begin
                o_word_in_page_field <= FWB'(low_part({head_reg.sub, rx_next}, FWB));
                o_page_index_field <= FPB'(high_part({head_reg.sub, rx_next}, FWB));
            end else if (head_reg.op == OP_LD_EEPROM) begin
                o_eeprom_byte_field <= EWB'(low_part({head_reg.sub, rx_next}, EWB));
                o_eeprom_page_field <= EPB'(high_part({head_reg.sub, rx_next}, EWB));
            end
        end
    end

endmodule : fuse_config_latch

// ### tb/isp_programmer_model.sv
// serial programmer on the far side of the download link
// assumes the device samples mosi on rising sck and shifts miso after falling sck
`timescale 1ns/10ps
module isp_programmer_model (
    input wire logic i_clk_sys,
    input wire logic i_miso,
    output logic o_reset_pin_n,
    output logic o_sck,
    output logic o_mosi
);
    // =====================================================
    // frame driver, sck idles low between frames
    initial begin
        o_reset_pin_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic set_pin(input logic v);
        @(posedge i_clk_sys);
        #1 o_reset_pin_n = v;
        repeat (8) @(posedge i_clk_sys);
    endtask : set_pin
    // four bytes msb first; miso taken at the edge that raises sck
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
        rx = '0;
        for (int i = 31; i >= 0; i--) begin
            @(posedge i_clk_sys);
            #1 o_mosi = cmd[i];
            repeat (5) @(posedge i_clk_sys);
            rx = {rx[30:0], i_miso};
            #1 o_sck = 1'b1;
            repeat (5) @(posedge i_clk_sys);
            #1 o_sck = 1'b0;
        end
        o_mosi = ~cmd[0];
    endtask : xfer
endmodule : isp_programmer_model

// ### tb/fuse_config_latch_assertions.sv
// timing checks on the configuration latch ports
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/10ps
module fuse_config_latch_checker
    import fuse_config_pkg::*;
#(
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic o_miso_oe,
    input wire logic o_prog_mode,
    input wire logic o_chip_erase,
    input wire logic o_eeprom_erase,
    input wire logic o_serial_download_permit,
    input wire logic o_watchdog_forced_on,
    input wire logic o_eeprom_keep_on_erase,
    input wire logic [2:0] o_brownout_level,
    input wire logic o_clock_div_eight,
    input wire logic [1:0] o_startup_time,
    input wire logic [3:0] o_clock_source_select,
    input wire logic [7:0] o_osc_trim_register
);
    // =====================================================
    // properties
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_reset_defaults: assert property ($fell(i_rst) |->
        o_clock_source_select == 4'h2 && o_startup_time == 2'h2 &&
        o_brownout_level == 3'h7 && o_clock_div_eight && !o_prog_mode)
        else $error("defaults wrong after reset");
    a_trim_cal: assert property ($fell(i_rst) |-> o_osc_trim_register == CAL_BYTE)
        else $error("trim not loaded");
    a_erase_pair: assert property (o_eeprom_erase |-> o_chip_erase)
        else $error("eeprom erase alone");
    a_erase_keep: assert property (o_chip_erase |->
        o_eeprom_erase == !o_eeprom_keep_on_erase)
        else $error("eeprom erase ignores keep bit");
    a_erase_pulse: assert property (o_chip_erase |=> !o_chip_erase)
        else $error("erase pulse too long");
    a_erase_prog: assert property (o_chip_erase |-> $past(o_prog_mode))
        else $error("erase outside programming mode");
    a_latch_hold: assert property (o_prog_mode && $past(o_prog_mode) |->
        $stable(o_clock_source_select) && $stable(o_watchdog_forced_on) &&
        $stable(o_brownout_level))
        else $error("controls moved in programming mode");
    a_prog_drop: assert property ($rose(i_reset_pin_n) |-> ##[1:6] !o_prog_mode)
        else $error("programming mode kept");
    a_oe_drop: assert property ($rose(i_reset_pin_n) |-> ##[1:6] !o_miso_oe)
        else $error("miso still driven");
    a_permit_fixed: assert property (o_serial_download_permit)
        else $error("serial permit lost");
    c_enter: cover property ($rose(o_prog_mode));
    c_keep_erase: cover property (o_chip_erase && o_eeprom_keep_on_erase);
    c_watchdog: cover property ($rose(o_watchdog_forced_on));
endmodule : fuse_config_latch_checker

bind fuse_config_latch fuse_config_latch_checker #(.CAL_BYTE(CAL_BYTE))
    fuse_config_latch_checker_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_pin_n(i_reset_pin_n), .o_miso_oe(o_miso_oe),
    .o_prog_mode(o_prog_mode), .o_chip_erase(o_chip_erase), .o_eeprom_erase(o_eeprom_erase),
    .o_serial_download_permit(o_serial_download_permit),
    .o_watchdog_forced_on(o_watchdog_forced_on), .o_eeprom_keep_on_erase(o_eeprom_keep_on_erase),
    .o_brownout_level(o_brownout_level), .o_clock_div_eight(o_clock_div_eight),
    .o_startup_time(o_startup_time), .o_clock_source_select(o_clock_source_select),
    .o_osc_trim_register(o_osc_trim_register));

// ### tb/fuse_config_latch_tb.sv
// self-checking bench for the configuration latch
// assumes the programmer model drives the reset pin, sck and mosi
`timescale 1ns/10ps
module fuse_config_latch_tb;
    import fuse_config_pkg::*;
    localparam logic [7:0] CAL = 8'h80;
    localparam logic [31:0] SIGS = 32'h5a3c01ff; // id values arbitrary
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic pin_n, sck, mosi, miso, oe, prog, cer, eer, selfw, rstoff, dbg, permit;
    logic wd, keep, div8, clock_pin_output;
    logic [1:0] sut, ebyte;
    logic [2:0] bod;
    logic [3:0] src, wip;
    logic [4:0] epage;
    logic [5:0] page;
    logic [7:0] trim, lv, hv;
    logic [15:0] a;
    logic [31:0] seed = 32'hbbcc;
    logic [31:0] rx;
    int fails = 0;
    int n_checks = 0;
    int n_eer = 0;
    wire [24:0] ctl_now = {selfw, rstoff, dbg, permit, wd, keep, bod, div8, clock_pin_output, sut, src, trim};

    always #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (eer === 1'b1) n_eer++;
    end

    // cal byte and the third id byte stay at the design defaults, equal to CAL and SIGS[15:8]
    fuse_config_latch #(.FLASH_PAGE_WORDS(16), .FLASH_PAGES(64), .EEPROM_PAGES(32),
        .SIG_BYTE0(SIGS[31:24]), .SIG_BYTE1(SIGS[23:16])) fuse_config_latch_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_pin_n(pin_n), .i_sck(sck), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(oe), .o_prog_mode(prog), .o_chip_erase(cer), .o_eeprom_erase(eer),
        .o_self_write_permit(selfw), .o_ext_reset_off(rstoff), .o_onewire_debug_on(dbg),
        .o_serial_download_permit(permit), .o_watchdog_forced_on(wd), .o_eeprom_keep_on_erase(keep),
        .o_brownout_level(bod), .o_clock_div_eight(div8), .o_clock_pin_output(clock_pin_output),
        .o_startup_time(sut), .o_clock_source_select(src), .o_osc_trim_register(trim),
        .o_word_in_page_field(wip), .o_page_index_field(page), .o_eeprom_byte_field(ebyte),
        .o_eeprom_page_field(epage));
    isp_programmer_model isp_programmer_model_i (.i_clk_sys(i_clk_sys), .i_miso(miso),
        .o_reset_pin_n(pin_n), .o_sck(sck), .o_mosi(mosi));

    // =====================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // expected control outputs from stored bytes, 0 = programmed
    function automatic logic [24:0] ctl(input logic [7:0] e, input logic [7:0] h,
        input logic [7:0] l);
        return {~e[0], ~h[7:3], h[2:0], ~l[7:6], l[5:0], CAL};
    endfunction : ctl
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic run(input logic [31:0] c);
        isp_programmer_model_i.xfer(c, rx);
        repeat (4) @(posedge i_clk_sys);
    endtask : run
    task automatic enter();
        isp_programmer_model_i.set_pin(1'b0);
        run(32'hac530000);
        chk(rx[15:8], 8'h53, "enable echo");
        chk(prog, 1'b1, "programming mode");
        chk(oe, 1'b1, "miso driven");
    endtask : enter
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (60000) @(posedge i_clk_sys);
        fails++;
        give_verdict();
    end

    // =====================================================
    // scenarios
    initial begin
        repeat (4) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk(ctl_now, ctl(8'hff, 8'hdf, 8'h62), "defaults");
        $display("test defaults done");
        isp_programmer_model_i.set_pin(1'b0);
        run(32'haca00000);
        chk(prog, 1'b0, "write before enable");
        enter();
        for (int k = 0; k < 4; k++) begin
            run({16'h3000, 6'h00, k[1:0], 8'h00});
            chk(rx[7:0], SIGS[31-8*k -: 8], "signature");
        end
        run(32'h38000000);
        chk(rx[7:0], CAL, "calibration");
        run(32'h50000000);
        chk(rx[7:0], 8'h62, "refused write");
        run(32'hac800000);
        chk(n_eer, 1, "eeprom erased");
        $display("test enable done");
        seed = xs(seed);
        lv = seed[7:0];
        hv = {2'b11, seed[13], 2'b00, seed[10:8]};
        run({24'haca000, lv});
        run({24'haca800, hv});
        run(32'haca40000);
        chk(keep, 1'b1, "keep at once");
        chk({wd, div8, src}, 6'h12, "held in mode");
        run(32'h58080000);
        chk(rx[7:0], 8'hdf, "latched high");
        run(32'hac800000);
        chk(n_eer, 1, "eeprom kept");
        isp_programmer_model_i.set_pin(1'b1);
        chk(ctl_now, ctl(8'hfe, hv & 8'hdf, lv), "applied on exit");
        chk(oe, 1'b0, "miso released");
        $display("test write done");
        enter();
        run(32'hace000fe);
        run({24'haca000, ~lv});
        run(32'h58000000);
        chk(rx[7:0], 8'hfe, "lock byte");
        run(32'h30000000);
        chk(rx[7:0], SIGS[31:24], "signature locked");
        a = seed[31:16];
        run({8'h40, a, 8'h00});
        run({16'hc100, a[7:0], 8'h00});
        chk({wip, page, ebyte, epage}, {a[3:0], a[9:4], a[1:0], a[6:2]}, "split");
        isp_programmer_model_i.set_pin(1'b1);
        chk(ctl_now, ctl(8'hfe, hv & 8'hdf, lv), "locked write");
        $display("test lock done");
        give_verdict();
    end
endmodule : fuse_config_latch_tb
